// file: logic/hprt_device.sv
// Device end of the host port: strobe decode, wait line and port registers.
// Assumes a DMA engine on sys_clk that answers each read request once.
//
// How it works
// - Access strobe is chip select OR strobes' XNOR.
// - Wait stays low while chip select high.
// - Wait high at select while earlier transfer completes.
// - First data read half fetches; wait until loaded.
// - Second half data write/autoincrement read: busy after.
// - Other accesses leave wait low after strobe, except one starting as busy ends: wait stays high two more periods.
// - Control and address accesses never raise wait; one that starts as a busy period ends keeps it high two more periods.
// - Host holds strobe low until wait low.
// - Read data valid two periods before ready.
// - Host strobe low and high four periods.
// - Latch strobe edge captures the select inputs.
// - Write data captured at strobe rising edge.
// - Drive bus after strobe falls, release after rise.
// - Host presents target, direction, half-word select.
// - Latch strobe pulsed at most once per access.
`timescale 1ns/10ps
module hprt_device (
    input wire logic sys_clk,
    input wire logic rst,
    hprt_if.device link,
    output logic dma_rd_req,
    output logic dma_wr_req,
    output logic [hprt_pkg::WORD_W-1:0] dma_addr,
    output logic [hprt_pkg::WORD_W-1:0] dma_wr_data,
    input wire logic dma_rd_valid,
    input wire logic [hprt_pkg::WORD_W-1:0] dma_rd_data,
    input wire logic dma_wr_ack,
    output logic [hprt_pkg::WORD_W-1:0] port_ctrl_value
);
    import hprt_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_SHOW = 3'h3,
        ST_ACCESS = 3'h2,
        ST_FINISH = 3'h6
    } hprt_dev_state_t;

    localparam int PIN_W = 8 + HALF_W;
    localparam logic [PIN_W-1:0] PIN_IDLE = 24'hf00000;
    localparam logic [CNT_W-1:0] LEAD_LAST = CNT_W'(DATA_LEAD_CYC - 1);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_q;

    assign pin_raw = {link.host_select_n, link.data_strobe_one, link.data_strobe_two,
        link.address_latch_strobe_n, link.access_target_select, link.host_read_write,
        link.halfword_order_select, link.host_data_bus};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_meta_q <= PIN_IDLE;
            pin_q <= PIN_IDLE;
        end
        else
        begin
            pin_meta_q <= pin_raw;
            pin_q <= pin_meta_q;
        end
    end

    logic cs_n;
    logic ds1;
    logic ds2;
    logic als_n;
    hprt_target_t pin_tgt;
    logic pin_rd;
    logic pin_hw;
    logic [HALF_W-1:0] pin_data;

    assign {cs_n, ds1, ds2, als_n} = pin_q[PIN_W-1:PIN_W-4];
    assign pin_tgt = hprt_target_t'(pin_q[PIN_W-5:PIN_W-6]);
    assign pin_rd = pin_q[HALF_W+1];
    assign pin_hw = pin_q[HALF_W];
    assign pin_data = pin_q[HALF_W-1:0];

    // ****************************************
    // Strobe decode and select capture
    // ****************************************
    logic strobe_n;
    logic als_prev_q;
    logic latched_q;
    hprt_target_t lat_tgt_q;
    logic lat_rd_q;
    logic lat_hw_q;
    hprt_target_t cur_tgt;
    logic cur_rd;
    logic cur_hw;
    hprt_dev_state_t st_q;
    logic [CNT_W-1:0] cnt_q;
    hprt_target_t acc_tgt_q;
    logic acc_rd_q;
    logic acc_hw_q;

    assign strobe_n = ~(ds1 ^ ds2) | cs_n;

    // A latch edge while no latch is held wins over the end of the access that clears the latch in the same cycle.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            als_prev_q <= 1'b1;
            latched_q <= 1'b0;
            lat_tgt_q <= TGT_CTRL;
            lat_rd_q <= 1'b0;
            lat_hw_q <= HW_FIRST;
        end
        else
        begin
            als_prev_q <= als_n;
            if (als_prev_q && !als_n && !latched_q)
            begin
                latched_q <= 1'b1;
                lat_tgt_q <= pin_tgt;
                lat_rd_q <= pin_rd;
                lat_hw_q <= pin_hw;
            end
            else if (st_q == ST_ACCESS && strobe_n)
            begin
                latched_q <= 1'b0;
            end
        end
    end

    assign cur_tgt = latched_q ? lat_tgt_q : pin_tgt;
    assign cur_rd = latched_q ? lat_rd_q : pin_rd;
    assign cur_hw = latched_q ? lat_hw_q : pin_hw;

    // ****************************************
    // Access sequencing
    // ****************************************
    logic start;
    logic need_fetch;
    logic acc_is_data;
    logic acc_end;
    logic post_busy;
    logic wr_go;
    logic finish_done;

    assign start = (st_q == ST_IDLE || finish_done) && !strobe_n;
    assign need_fetch = start && (cur_tgt == TGT_DATA || cur_tgt == TGT_DATA_INC)
        && cur_rd == RW_READ && cur_hw == HW_FIRST;
    assign acc_is_data = (acc_tgt_q == TGT_DATA) || (acc_tgt_q == TGT_DATA_INC);
    assign acc_end = (st_q == ST_ACCESS) && strobe_n;
    assign post_busy = acc_end && acc_is_data && acc_hw_q == HW_SECOND
        && (acc_rd_q != RW_READ || acc_tgt_q == TGT_DATA_INC);
    assign wr_go = post_busy && acc_rd_q != RW_READ;
    assign finish_done = (st_q == ST_FINISH) && (acc_rd_q == RW_READ || dma_wr_ack);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        st_q <= need_fetch ? ST_FETCH : ST_ACCESS;
                    end
                end
                ST_FETCH:
                begin
                    if (dma_rd_valid)
                    begin
                        st_q <= ST_SHOW;
                        cnt_q <= '0;
                    end
                end
                ST_SHOW:
                begin
                    if (cnt_q == LEAD_LAST)
                    begin
                        st_q <= ST_ACCESS;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_ACCESS:
                begin
                    if (strobe_n)
                    begin
                        st_q <= post_busy ? ST_FINISH : ST_IDLE;
                    end
                end
                ST_FINISH:
                begin
                    if (finish_done)
                    begin
                        st_q <= !start ? ST_IDLE : need_fetch ? ST_FETCH : ST_SHOW;
                        cnt_q <= '0;
                    end
                end
                default:
                begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            acc_tgt_q <= TGT_CTRL;
            acc_rd_q <= 1'b0;
            acc_hw_q <= HW_FIRST;
        end
        else if (start)
        begin
            acc_tgt_q <= cur_tgt;
            acc_rd_q <= cur_rd;
            acc_hw_q <= cur_hw;
        end
    end

    // A strobe that falls during a busy period is served only after it ends,
    // and the wait line tells the host so as soon as it selects.
    assign link.port_wait_out = !cs_n
        && (st_q == ST_FETCH || st_q == ST_SHOW || st_q == ST_FINISH);

    // ****************************************
    // Port registers
    // ****************************************
    logic [WORD_W-1:0] ctrl_q;
    logic [WORD_W-1:0] addr_q;
    logic [WORD_W-1:0] data_q;
    logic wr_ctrl;
    logic wr_addr;
    logic wr_data;

    function automatic logic [WORD_W-1:0] put_half(input logic [WORD_W-1:0] old,
        input logic hw, input logic [HALF_W-1:0] d);
        put_half = (hw == HW_SECOND) ? {d, old[HALF_W-1:0]} : {old[WORD_W-1:HALF_W], d};
    endfunction

    assign wr_ctrl = acc_end && acc_rd_q != RW_READ && acc_tgt_q == TGT_CTRL;
    assign wr_addr = acc_end && acc_rd_q != RW_READ && acc_tgt_q == TGT_ADDR;
    assign wr_data = acc_end && acc_rd_q != RW_READ && acc_is_data;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_q <= CTRL_RST;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= put_half(ctrl_q, acc_hw_q, pin_data);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            addr_q <= ADDR_RST;
        end
        else if (wr_addr)
        begin
            addr_q <= put_half(addr_q, acc_hw_q, pin_data);
        end
        else if (finish_done && acc_tgt_q == TGT_DATA_INC)
        begin
            addr_q <= addr_q + ADDR_STEP;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            data_q <= DATA_RST;
        end
        else if (wr_data)
        begin
            data_q <= put_half(data_q, acc_hw_q, pin_data);
        end
        else if (st_q == ST_FETCH && dma_rd_valid)
        begin
            data_q <= dma_rd_data;
        end
    end

    // ****************************************
    // DMA requests and read drive
    // ****************************************
    logic rd_req_q;
    logic wr_req_q;
    logic [HALF_W-1:0] dout_q;
    logic doe_q;
    logic [WORD_W-1:0] rd_word;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rd_req_q <= 1'b0;
            wr_req_q <= 1'b0;
        end
        else
        begin
            rd_req_q <= need_fetch;
            wr_req_q <= wr_go;
        end
    end

    always_comb
    begin
        if (cur_tgt == TGT_CTRL)
        begin
            rd_word = ctrl_q;
        end
        else if (cur_tgt == TGT_ADDR)
        begin
            rd_word = addr_q;
        end
        else
        begin
            rd_word = data_q;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            dout_q <= '0;
            doe_q <= 1'b0;
        end
        else if (start && cur_rd == RW_READ && !need_fetch)
        begin
            doe_q <= 1'b1;
            dout_q <= (cur_hw == HW_SECOND) ? rd_word[WORD_W-1:HALF_W] : rd_word[HALF_W-1:0];
        end
        else if (st_q == ST_FETCH && dma_rd_valid)
        begin
            doe_q <= 1'b1;
            dout_q <= dma_rd_data[HALF_W-1:0];
        end
        else if (acc_end)
        begin
            doe_q <= 1'b0;
        end
    end

    assign dma_rd_req = rd_req_q;
    assign dma_wr_req = wr_req_q;
    assign dma_addr = addr_q;
    assign dma_wr_data = data_q;
    assign port_ctrl_value = ctrl_q;
    assign link.dev_data_out = dout_q;
    assign link.dev_data_oe = doe_q;

endmodule // hprt_device

// file: logic/hprt_host.sv
// Host end of the port: runs one 32-bit command as two half-word accesses.
// Assumes the device end on the same interface; pins are resynchronised here.
`timescale 1ns/10ps
module hprt_host #(
    parameter bit USE_LATCH = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    hprt_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire hprt_pkg::hprt_target_t cmd_target,
    input wire logic cmd_read,
    input wire logic [hprt_pkg::WORD_W-1:0] cmd_wdata,
    output logic rsp_valid,
    output logic [hprt_pkg::WORD_W-1:0] rsp_rdata
);
    import hprt_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_SETUP = 2'h1,
        H_LOW = 2'h3,
        H_HIGH = 2'h2
    } hprt_host_state_t;

    // The wait line seen here lags the strobe by a round trip, so the strobe
    // stays low long enough that a stale ready cannot end the access early.
    localparam int LOW_HOLD = (STB_LOW_CYC > LINK_SETTLE_CYC) ? STB_LOW_CYC : LINK_SETTLE_CYC;
    localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(LOW_HOLD - 1);
    localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(STB_HIGH_CYC - 1);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [HALF_W:0] in_meta_q;
    logic [HALF_W:0] in_q;
    logic wait_s;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            in_meta_q <= '0;
            in_q <= '0;
        end
        else
        begin
            in_meta_q <= {link.port_wait_out, link.host_data_bus};
            in_q <= in_meta_q;
        end
    end

    assign wait_s = in_q[HALF_W];

    // ****************************************
    // Access sequencer
    // ****************************************
    hprt_host_state_t st_q;
    logic [CNT_W-1:0] cnt_q;
    hprt_target_t tgt_q;
    logic rd_q;
    logic hw_q;
    logic [WORD_W-1:0] wdata_q;
    logic [WORD_W-1:0] rdata_q;
    logic cs_n_q;
    logic ds1_q;
    logic als_n_q;
    logic [HALF_W-1:0] dout_q;
    logic doe_q;
    logic rsp_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= H_IDLE;
            cnt_q <= '0;
            tgt_q <= TGT_CTRL;
            rd_q <= 1'b0;
            hw_q <= HW_FIRST;
            wdata_q <= '0;
            rdata_q <= '0;
            cs_n_q <= 1'b1;
            ds1_q <= 1'b1;
            als_n_q <= 1'b1;
            dout_q <= '0;
            doe_q <= 1'b0;
            rsp_q <= 1'b0;
        end
        else
        begin
            rsp_q <= 1'b0;
            case (st_q)
                H_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        tgt_q <= cmd_target;
                        rd_q <= cmd_read;
                        hw_q <= HW_FIRST;
                        wdata_q <= cmd_wdata;
                        cs_n_q <= 1'b0;
                        als_n_q <= !USE_LATCH;
                        dout_q <= cmd_wdata[HALF_W-1:0];
                        doe_q <= !cmd_read;
                        st_q <= H_SETUP;
                    end
                end
                H_SETUP:
                begin
                    ds1_q <= 1'b0;
                    cnt_q <= '0;
                    st_q <= H_LOW;
                end
                H_LOW:
                begin
                    als_n_q <= 1'b1;
                    if (cnt_q != LOW_LAST)
                    begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                    else if (!wait_s)
                    begin
                        ds1_q <= 1'b1;
                        cnt_q <= '0;
                        if (rd_q == RW_READ && hw_q == HW_SECOND)
                        begin
                            rdata_q[WORD_W-1:HALF_W] <= in_q[HALF_W-1:0];
                        end
                        else if (rd_q == RW_READ)
                        begin
                            rdata_q[HALF_W-1:0] <= in_q[HALF_W-1:0];
                        end
                        st_q <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    if (cnt_q == '0)
                    begin
                        doe_q <= 1'b0;
                    end
                    if (cnt_q != HIGH_LAST)
                    begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                    else if (hw_q == HW_FIRST)
                    begin
                        hw_q <= HW_SECOND;
                        als_n_q <= !USE_LATCH;
                        dout_q <= wdata_q[WORD_W-1:HALF_W];
                        doe_q <= !rd_q;
                        st_q <= H_SETUP;
                    end
                    else
                    begin
                        cs_n_q <= 1'b1;
                        rsp_q <= 1'b1;
                        st_q <= H_IDLE;
                    end
                end
                default:
                begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    assign cmd_ready = (st_q == H_IDLE);
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;
    assign link.host_select_n = cs_n_q;
    assign link.data_strobe_one = ds1_q;
    assign link.data_strobe_two = 1'b1;
    assign link.address_latch_strobe_n = als_n_q;
    assign link.access_target_select = tgt_q;
    assign link.host_read_write = rd_q;
    assign link.halfword_order_select = hw_q;
    assign link.host_data_out = dout_q;
    assign link.host_data_oe = doe_q;

endmodule // hprt_host

// file: pkg/hprt_if.sv
// Pins between the external host and the device's host port.
// The shared data bus level is resolved here from both drive enables.
`timescale 1ns/10ps
interface hprt_if;
    logic host_select_n;
    logic data_strobe_one;
    logic data_strobe_two;
    logic address_latch_strobe_n;
    logic [1:0] access_target_select;
    logic host_read_write;
    logic halfword_order_select;
    logic port_wait_out;
    logic [15:0] host_data_out;
    logic host_data_oe;
    logic [15:0] dev_data_out;
    logic dev_data_oe;
    logic [15:0] host_data_bus;

    assign host_data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 16'h0);

    modport device (
        input host_select_n,
        input data_strobe_one,
        input data_strobe_two,
        input address_latch_strobe_n,
        input access_target_select,
        input host_read_write,
        input halfword_order_select,
        input host_data_bus,
        output port_wait_out,
        output dev_data_out,
        output dev_data_oe
    );

    modport host (
        output host_select_n,
        output data_strobe_one,
        output data_strobe_two,
        output address_latch_strobe_n,
        output access_target_select,
        output host_read_write,
        output halfword_order_select,
        output host_data_out,
        output host_data_oe,
        input host_data_bus,
        input port_wait_out
    );
endinterface // hprt_if

// file: pkg/hprt_pkg.sv
// Shared constants and types of the parallel host port handshake.
// Assumes one system clock; CPU period P equals the system clock period.
package hprt_pkg;

    // ****************************************
    // Widths and timing
    // ****************************************
    localparam int HALF_W = 16;
    localparam int WORD_W = 32;
    localparam int CNT_W = 4;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CPU_PERIOD_NS = 100;
    localparam int STB_LOW_MIN_NS = 4 * CPU_PERIOD_NS;
    localparam int STB_HIGH_MIN_NS = 4 * CPU_PERIOD_NS;
    localparam int DATA_LEAD_NS = 2 * CPU_PERIOD_NS;
    localparam int STB_LOW_CYC = (STB_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STB_HIGH_CYC = (STB_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Two synchroniser stages each way plus the strobe, state and decision register cycles.
    localparam int LINK_SETTLE_CYC = 7;

    // ****************************************
    // Encodings and reset values
    // ****************************************
    typedef enum logic [1:0] {
        TGT_CTRL = 2'h0,
        TGT_DATA_INC = 2'h1,
        TGT_ADDR = 2'h2,
        TGT_DATA = 2'h3
    } hprt_target_t;
    localparam logic HW_FIRST = 1'h0;
    localparam logic HW_SECOND = 1'h1;
    localparam logic RW_READ = 1'h1;
    localparam logic [WORD_W-1:0] ADDR_STEP = 32'h4;
    localparam logic [WORD_W-1:0] CTRL_RST = 32'h0;
    localparam logic [WORD_W-1:0] ADDR_RST = 32'h0;
    localparam logic [WORD_W-1:0] DATA_RST = 32'h0;

endpackage

// file: tb/hprt_checker.sv
// Pin-level checks on the host port link between host and device ends.
// Assumes both ends run on sys_clk with the synchronous reset rst.
`timescale 1ns/10ps
module hprt_checker
    import hprt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic host_select_n,
    input wire logic data_strobe_one,
    input wire logic data_strobe_two,
    input wire logic [1:0] access_target_select,
    input wire logic host_read_write,
    input wire logic halfword_order_select,
    input wire logic port_wait_out,
    input wire logic dev_data_oe
);
    // ****************************************
    // Strobe decode and sequences
    // ****************************************
    logic stb;
    assign stb = ~(data_strobe_one ^ data_strobe_two) | host_select_n;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence fetch_show_s;
        port_wait_out ##1 port_wait_out ##1 !port_wait_out;
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    a_ready_when_idle: assert property (host_select_n && $past(host_select_n, 2)
        |-> !port_wait_out)
        else $error("wait high while deselected");
    a_stb_low_min: assert property ($fell(stb) |-> !stb[*4])
        else $error("strobe low too short");
    a_stb_high_min: assert property ($rose(stb) |-> stb[*4])
        else $error("strobe high too short");
    a_hold_to_ready: assert property ($rose(stb) |->
        !$past(port_wait_out) && !$past(port_wait_out, 2))
        else $error("strobe released before ready");
    a_data_lead: assert property ($rose(dev_data_oe) && port_wait_out |-> fetch_show_s)
        else $error("read data lead wrong");
    a_drive_after_stb: assert property ($fell(stb) |-> !dev_data_oe)
        else $error("bus driven before strobe fell");
    a_release_bus: assert property ($rose(stb) |-> ##[1:4] !dev_data_oe)
        else $error("bus not released after strobe");
    a_fetch_busy: assert property ($fell(stb) && host_read_write && access_target_select[0]
        && halfword_order_select == HW_FIRST |-> ##[1:6] port_wait_out)
        else $error("no busy on first data read half");
    a_ctrl_no_wait: assert property ($rose(port_wait_out) && !$past(host_select_n, 3)
        |-> access_target_select[0])
        else $error("wait rose on control or address access");
    a_plain_stays_low: assert property ($rose(stb) && (!access_target_select[0]
        || host_read_write && access_target_select == TGT_DATA) |-> !port_wait_out[*5])
        else $error("wait rose after plain access");
endmodule // hprt_checker

// file: tb/tb.sv
// Self-checking bench: host end drives device end; the bench plays the DMA engine.
// Assumes both ends share the 10 MHz sys_clk.
`timescale 1ns/10ps
module tb;
    import hprt_pkg::*;
    typedef struct {
        hprt_target_t tgt;
        logic rd;
        logic [WORD_W-1:0] wd;
        logic [WORD_W-1:0] exp;
        logic [WORD_W-1:0] exp_addr;
        int dly;
    } hprt_row_t;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic cmd_valid = 1'h0;
    logic cmd_ready;
    hprt_target_t cmd_target = TGT_CTRL;
    logic cmd_read = 1'h0;
    logic [WORD_W-1:0] cmd_wdata = 32'h0;
    logic rsp_valid;
    logic [WORD_W-1:0] rsp_rdata, dma_addr, dma_wr_data, port_ctrl_value, wr_last, rd_addr;
    logic [WORD_W-1:0] dma_rd_data = 32'h0;
    logic dma_rd_req, dma_wr_req;
    logic dma_rd_valid = 1'h0;
    logic dma_wr_ack = 1'h0;
    logic [2:0] sel_hist = 3'h7;
    logic busy_sel = 1'h0;
    int err_count = 0, compares = 0, rd_cnt = 0, wr_cnt = 0, wr_seen = 0, exp_wr = 0, dly = 1;
    hprt_row_t rows [9];
    hprt_if link();

    always #50 sys_clk = ~sys_clk;

    hprt_device hprt_device_i (.sys_clk(sys_clk), .rst(rst), .link(link),
        .dma_rd_req(dma_rd_req), .dma_wr_req(dma_wr_req), .dma_addr(dma_addr),
        .dma_wr_data(dma_wr_data), .dma_rd_valid(dma_rd_valid), .dma_rd_data(dma_rd_data),
        .dma_wr_ack(dma_wr_ack), .port_ctrl_value(port_ctrl_value));
    hprt_host hprt_host_i (.sys_clk(sys_clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_target(cmd_target), .cmd_read(cmd_read),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    hprt_checker hprt_checker_i (.sys_clk(sys_clk), .rst(rst),
        .host_select_n(link.host_select_n), .data_strobe_one(link.data_strobe_one),
        .data_strobe_two(link.data_strobe_two), .access_target_select(link.access_target_select),
        .host_read_write(link.host_read_write), .halfword_order_select(link.halfword_order_select),
        .port_wait_out(link.port_wait_out), .dev_data_oe(link.dev_data_oe));

    // ****************************************
    // DMA engine model, answers after dly cycles
    // ****************************************
    always @(negedge sys_clk)
    begin
        dma_rd_valid <= 1'h0;
        dma_wr_ack <= 1'h0;
        if (rd_cnt > 0 && --rd_cnt == 0)
        begin
            dma_rd_valid <= 1'h1;
            dma_rd_data <= ~rd_addr;
        end
        if (wr_cnt > 0 && --wr_cnt == 0)
            dma_wr_ack <= 1'h1;
        if (dma_rd_req === 1'h1)
        begin
            rd_cnt = dly;
            rd_addr = dma_addr;
        end
        if (dma_wr_req === 1'h1)
        begin
            wr_cnt = dly;
            wr_last = dma_wr_data;
            wr_seen++;
        end
        if (sel_hist[2] === 1'h1 && link.host_select_n === 1'h0 && link.port_wait_out === 1'h1)
            busy_sel <= 1'h1;
        sel_hist <= {sel_hist[1:0], link.host_select_n};
    end

    task automatic stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic run_cmd(input hprt_target_t t, input logic r, input logic [WORD_W-1:0] w);
        int n = 0;
        @(negedge sys_clk);
        cmd_valid = 1'h1;
        cmd_target = t;
        cmd_read = r;
        cmd_wdata = w;
        while (cmd_ready !== 1'h1 && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        cmd_valid = 1'h0;
        while (rsp_valid !== 1'h1 && n < 800)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 800)
        begin
            err_count++;
            stop_test();
        end
    endtask

    initial
    begin
        rows = '{'{TGT_ADDR, 1'h0, 32'h100, 32'h100, 32'h100, 1},
            '{TGT_CTRL, 1'h0, 32'h1234abcd, 32'h1234abcd, 32'h100, 1},
            '{TGT_CTRL, 1'h1, 32'h0, 32'h1234abcd, 32'h100, 1},
            '{TGT_ADDR, 1'h1, 32'h0, 32'h100, 32'h100, 1},
            '{TGT_DATA, 1'h0, 32'hcafe0001, 32'hcafe0001, 32'h100, 1},
            '{TGT_DATA_INC, 1'h0, 32'h5555aaaa, 32'h5555aaaa, 32'h104, 6},
            '{TGT_DATA, 1'h1, 32'h0, 32'hfffffefb, 32'h104, 9},
            '{TGT_DATA_INC, 1'h1, 32'h0, 32'hfffffefb, 32'h108, 1},
            '{TGT_ADDR, 1'h1, 32'h0, 32'h108, 32'h108, 1}};
        repeat (10) @(negedge sys_clk);
        rst = 1'h0;
        foreach (rows[i])
        begin
            int n = 0;
            dly = rows[i].dly;
            if (!rows[i].rd && rows[i].tgt[0])
                exp_wr++;
            run_cmd(rows[i].tgt, rows[i].rd, rows[i].wd);
            while (!(wr_seen == exp_wr && wr_cnt == 0 && dma_addr === rows[i].exp_addr) && n < 30)
            begin
                @(negedge sys_clk);
                n++;
            end
            if (n >= 30)
            begin
                err_count++;
                stop_test();
            end
            check("addr", rows[i].exp_addr, dma_addr);
            check("data", rows[i].exp, rows[i].rd ? rsp_rdata : rows[i].tgt == TGT_CTRL
                ? port_ctrl_value : rows[i].tgt == TGT_ADDR ? dma_addr : wr_last);
        end
        // A slow write completion must hold off the next access and show wait at its select.
        dly = 20;
        run_cmd(TGT_DATA, 1'h0, 32'h0badf00d);
        run_cmd(TGT_CTRL, 1'h1, 32'h0);
        check("busy at select", 32'h1, {31'h0, busy_sel});
        check("slow write", 32'h0badf00d, wr_last);
        check("ctrl read", 32'h1234abcd, rsp_rdata);
        @(negedge sys_clk);
        rst = 1'h1;
        repeat (10) @(negedge sys_clk);
        rst = 1'h0;
        check("ctrl reset", CTRL_RST, port_ctrl_value);
        check("addr reset", ADDR_RST, dma_addr);
        check("wait reset", 32'h0, {31'h0, link.port_wait_out});
        check("oe reset", 32'h0, {31'h0, link.dev_data_oe});
        run_cmd(TGT_CTRL, 1'h1, 32'h0);
        check("ctrl after reset", CTRL_RST, rsp_rdata);
        stop_test();
    end
endmodule // tb
